// ==== design/psw_pkg.sv ====
// Constants and carrier types for the processor status and direct-window logic.
// Assumes a single pclk domain and an APB master that holds requests until pready.
package psw_pkg;
    // APB register byte offsets
    localparam logic [11:0] OFS_STATUS_WORD = 12'h000;
    localparam logic [11:0] OFS_MIRROR      = 12'h004;
    localparam logic [11:0] OFS_OPERATION   = 12'h008;
    localparam logic [11:0] OFS_RESULT      = 12'h00C;
    localparam logic [11:0] OFS_DIRECT      = 12'h010;
    localparam logic [11:0] OFS_IRQ         = 12'h014;
    localparam logic [11:0] OFS_WORD        = 12'h018;
    localparam logic [11:0] OFS_BANKREG     = 12'h01C;
    // Status word field positions
    localparam int BANK_LSB   = 11;
    localparam int WINDOW_LSB = 8;
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_I = 4;
    localparam int FLAG_IL0 = 5;
    localparam int FLAG_H = 7;
    // Reset values
    localparam logic [15:0] STATUS_RESET = 16'h0060;
    localparam logic [1:0]  LEVEL_NONE   = 2'h3;
    // Address map figures
    localparam logic [15:0] LOW_LAST      = 16'h007F;
    localparam logic [15:0] HOLE_LAST     = 16'h008F;
    localparam logic [15:0] WINDOW_BASE   = 16'h0080;
    localparam logic [15:0] BANK_BASE     = 16'h0100;
    localparam logic [15:0] BANK_LAST_SML = 16'h018F;
    localparam logic [15:0] MIRROR_ADDR   = 16'h0078;
    localparam int NUM_BANKS = 32;
    localparam int BANK_REGS = 8;

    // Operation codes for the flag unit
    typedef enum logic [3:0] {
        OP_NONE, OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_LOGIC,
        OP_SHL, OP_SHR, OP_MASK_RELEASE_OP, OP_MASK_ASSERT_OP, OP_MOVE
    } op_type;

    // Flag-unit request carried from the APB write
    typedef struct packed {
        op_type     op;
        logic [7:0] a;
        logic [7:0] b;
    } alu_req_type;

    // Split word for memory placement
    typedef struct packed {
        logic [7:0] low_addr_byte;
        logic [7:0] high_addr_byte;
    } word_bytes_type;
endpackage : psw_pkg

// ==== design/psw_core.sv ====
// Processor status word, flag unit, direct window mapping, interrupt gate
// and banked register storage, reached over an APB slave.
// Assumes one pclk domain; peripheral requests arrive asynchronously.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module psw_core
    import psw_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [23:0] peripheral_request_lines,
    input  wire logic [47:0] source_priority_regs,
    input  wire logic        small_ram,
    output logic             irq_accept,
    output logic [4:0]       irq_source
);
    logic [15:0] processor_status_word_r;
    logic [7:0]  result_r;
    logic [15:0] direct_phys_r;
    logic        direct_valid_r;
    logic [15:0] word_r;
    logic [7:0]  bank_slot_regs [NUM_BANKS*BANK_REGS];
    logic [2:0]  slot_idx_r;
    logic [23:0] req_meta_r;
    logic [23:0] req_sync_r;
    logic [31:0] prdata_nxt;
    logic        pslverr_nxt;
    logic        irq_accept_nxt;
    logic [4:0]  irq_source_nxt;
    logic        wr_en;
    logic        rd_en;
    alu_req_type req;
    logic [15:0] flags_nxt;
    logic [7:0]  res_nxt;

    wire [4:0] bank_select_pointer   = processor_status_word_r[15:BANK_LSB];
    wire [2:0] direct_window_select  = processor_status_word_r[10:WINDOW_LSB];
    wire [1:0] accepted_priority_field = processor_status_word_r[6:FLAG_IL0];

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign req = alu_req_type'(pwdata[19:0]);

    // Maps an 8-bit direct operand through the window selector
    function automatic logic [16:0] map_direct(input logic [7:0] opnd, input logic [2:0] win);
        logic [15:0] phys;
        phys = {8'h00, opnd};
        if (opnd <= LOW_LAST[7:0]) begin
            return {1'b1, phys};
        end
        if (win == 3'h0) begin
            return {(phys > HOLE_LAST), phys};
        end
        phys = BANK_BASE + {6'h00, win - 3'h1, 7'h00} + (phys - WINDOW_BASE);
        return {1'b1, phys};
    endfunction : map_direct

    // Flag unit: computes result and next flags for one operation
    always_comb begin
        logic [8:0] sum;
        logic [4:0] half;
        logic       cin;
        sum = 9'h000;
        half = 5'h00;
        cin = (req.op == OP_ADDC || req.op == OP_SUBC) ? processor_status_word_r[FLAG_C] : 1'b0;
        flags_nxt = processor_status_word_r;
        res_nxt = result_r;
        case (req.op)
            OP_ADD, OP_ADDC: begin
                sum = {1'b0, req.a} + {1'b0, req.b} + {8'h00, cin};
                half = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, cin};
                res_nxt = sum[7:0];
                flags_nxt[FLAG_H] = half[4];
                flags_nxt[FLAG_C] = sum[8];
                flags_nxt[FLAG_V] = (req.a[7] == req.b[7]) && (sum[7] != req.a[7]);
            end
            OP_SUB, OP_SUBC: begin
                sum = {1'b0, req.a} - {1'b0, req.b} - {8'h00, cin};
                half = {1'b0, req.a[3:0]} - {1'b0, req.b[3:0]} - {4'h0, cin};
                res_nxt = sum[7:0];
                flags_nxt[FLAG_H] = half[4];
                flags_nxt[FLAG_C] = sum[8];
                flags_nxt[FLAG_V] = (req.a[7] != req.b[7]) && (sum[7] != req.a[7]);
            end
            OP_SHL: begin
                res_nxt = {req.a[6:0], 1'b0};
                flags_nxt[FLAG_C] = req.a[7];
            end
            OP_SHR: begin
                res_nxt = {1'b0, req.a[7:1]};
                flags_nxt[FLAG_C] = req.a[0];
            end
            OP_LOGIC, OP_MOVE: begin
                res_nxt = req.a & req.b;
                if (req.op == OP_MOVE) begin
                    res_nxt = req.a;
                end
            end
            OP_MASK_RELEASE_OP: flags_nxt[FLAG_I] = 1'b1;
            OP_MASK_ASSERT_OP: flags_nxt[FLAG_I] = 1'b0;
            default: ;
        endcase
        // N and Z follow every result-producing operation
        if (req.op inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBC,
                           OP_SHL, OP_SHR, OP_LOGIC, OP_MOVE}) begin
            flags_nxt[FLAG_N] = res_nxt[7];
            flags_nxt[FLAG_Z] = (res_nxt == 8'h00);
        end
    end

    // Status word: whole-word write, mirror write of pointers, flag unit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            processor_status_word_r <= STATUS_RESET;
        end else if (wr_en && paddr == OFS_STATUS_WORD) begin
            processor_status_word_r <= pwdata[15:0];
        end else if (wr_en && paddr == OFS_MIRROR) begin
            processor_status_word_r[15:8] <= pwdata[7:0];
        end else if (wr_en && paddr == OFS_OPERATION) begin
            processor_status_word_r <= flags_nxt;
        end
    end

    // Result byte from the flag unit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= 8'h00;
        end else if (wr_en && paddr == OFS_OPERATION) begin
            result_r <= res_nxt;
        end
    end

    // Direct operand translation, latched on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direct_phys_r  <= 16'h0000;
            direct_valid_r <= 1'b0;
        end else if (wr_en && paddr == OFS_DIRECT) begin
            {direct_valid_r, direct_phys_r} <= map_direct(pwdata[7:0], direct_window_select);
        end
    end

    // Word register; read view puts upper byte at lower address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_r <= 16'h0000;
        end else if (wr_en && paddr == OFS_WORD) begin
            word_r <= pwdata[15:0];
        end
    end

    // Banked register file, bank pointer plus write data bits 10:8
    always_ff @(posedge pclk) begin
        if (wr_en && paddr == OFS_BANKREG
            && !(small_ram && bank_select_pointer > 5'h11)) begin
            bank_slot_regs[{bank_select_pointer, pwdata[10:8]}] <= pwdata[7:0];
        end
    end

    // Slot index for bank reads, taken from write data bits 10:8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_idx_r <= 3'h0;
        end else if (wr_en && paddr == OFS_BANKREG) begin
            slot_idx_r <= pwdata[10:8];
        end
    end

    // Two-stage synchroniser for peripheral requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_meta_r <= 24'h000000;
            req_sync_r <= 24'h000000;
        end else begin
            req_meta_r <= peripheral_request_lines;
            req_sync_r <= req_meta_r;
        end
    end

    // Acceptance: lowest-numbered source whose level beats the accepted field
    always_comb begin
        irq_accept_nxt = 1'b0;
        irq_source_nxt = 5'h00;
        for (int i = 23; i >= 0; i--) begin
            if (req_sync_r[i] && processor_status_word_r[FLAG_I]
                && source_priority_regs[2*i +: 2] < accepted_priority_field) begin
                irq_accept_nxt = 1'b1;
                irq_source_nxt = 5'(i);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_accept <= 1'b0;
            irq_source <= 5'h00;
        end else begin
            irq_accept <= irq_accept_nxt;
            irq_source <= irq_source_nxt;
        end
    end

    // Read mux; unmapped addresses answer with an error
    always_comb begin
        word_bytes_type wb;
        wb = {word_r[15:8], word_r[7:0]};
        prdata_nxt = 32'h00000000;
        pslverr_nxt = 1'b0;
        case (paddr)
            OFS_STATUS_WORD: prdata_nxt = {16'h0000, processor_status_word_r};
            OFS_MIRROR:      prdata_nxt = {24'h000000, processor_status_word_r[15:8]};
            OFS_RESULT:      prdata_nxt = {24'h000000, result_r};
            OFS_DIRECT:      prdata_nxt = {15'h0000, direct_valid_r, direct_phys_r};
            OFS_IRQ:         prdata_nxt = {26'h0000000, irq_accept, irq_source};
            OFS_WORD:        prdata_nxt = {16'h0000, wb};
            OFS_BANKREG:     prdata_nxt = {24'h000000,
                                           bank_slot_regs[{bank_select_pointer, slot_idx_r}]};
            OFS_OPERATION:   prdata_nxt = 32'h00000000;
            default:         pslverr_nxt = 1'b1;
        endcase
    end

    assign prdata  = rd_en ? prdata_nxt : 32'h00000000;
    assign pslverr = psel && penable && pslverr_nxt;

    // Reference values for the checks, worked out apart from the flag unit
    wire              half_ref   = req.a[3:0] > (4'hF - req.b[3:0]);
    wire              carry_ref  = req.a > (8'hFF - req.b);
    wire              borrow_ref = req.a < req.b;
    wire signed [8:0] ssum_ref   = $signed({req.a[7], req.a}) + $signed({req.b[7], req.b});
    wire              ovf_ref    = ssum_ref[8] ^ ssum_ref[7];
    wire [1:0]        won_level  = source_priority_regs[{irq_source, 1'b0} +: 2];

    // Interrupt gate checks
    chk_enable_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        !processor_status_word_r[FLAG_I] |=> !irq_accept)
        else $error("accept while disabled");
    chk_level_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> accepted_priority_field == LEVEL_NONE)
        else $error("level reset");
    chk_accept_below: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_accept && $stable(source_priority_regs) && $stable(processor_status_word_r)
        |-> processor_status_word_r[FLAG_I] && won_level < accepted_priority_field)
        else $error("accepted level not below field");
    // Flag unit checks
    chk_mask_release_op_op: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_MASK_RELEASE_OP
        |=> processor_status_word_r[FLAG_I])
        else $error("mask_release_op failed");
    chk_mask_assert_op_op: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_MASK_ASSERT_OP
        |=> !processor_status_word_r[FLAG_I])
        else $error("mask_assert_op failed");
    chk_half_add: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_ADD
        |=> processor_status_word_r[FLAG_H] == $past(half_ref))
        else $error("half carry on add");
    chk_add_carry: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_ADD
        |=> processor_status_word_r[FLAG_C] == $past(carry_ref))
        else $error("carry on add");
    chk_sub_borrow: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_SUB
        |=> processor_status_word_r[FLAG_C] == $past(borrow_ref))
        else $error("borrow on subtract");
    chk_add_overflow: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_ADD
        |=> processor_status_word_r[FLAG_V] == $past(ovf_ref))
        else $error("overflow on add");
    chk_zero_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_MOVE
        |=> processor_status_word_r[FLAG_Z] == (result_r == 8'h00))
        else $error("zero flag");
    chk_neg_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_MOVE
        |=> processor_status_word_r[FLAG_N] == result_r[7])
        else $error("neg flag");
    chk_shift_carry: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_SHL
        |=> processor_status_word_r[FLAG_C] == $past(req.a[7]))
        else $error("shift carry");
    chk_shr_carry: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_SHR
        |=> processor_status_word_r[FLAG_C] == $past(req.a[0]))
        else $error("right shift carry");
    chk_noop_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_OPERATION && req.op == OP_NONE
        |=> $stable(processor_status_word_r))
        else $error("idle operation changed status");
    // Direct window checks
    chk_low_map: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_DIRECT && pwdata[7:0] <= 8'h7F
        |=> direct_phys_r == {8'h00, $past(pwdata[7:0])})
        else $error("low map");
    chk_hole_skip: assert property (
        @(posedge pclk) disable iff (!presetn)
        direct_valid_r |-> !(direct_phys_r > 16'h007F && direct_phys_r < 16'h0090))
        else $error("hole reached");
    chk_window_map: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_DIRECT && pwdata[7] && direct_window_select != 3'h0
        |=> direct_valid_r && direct_phys_r[6:0] == $past(pwdata[6:0])
            && direct_phys_r[15:7] == {6'h00, $past(direct_window_select)} + 9'h001)
        else $error("window mapping");
    // Status word and storage checks
    chk_status_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_STATUS_WORD
        |=> processor_status_word_r == $past(pwdata[15:0]))
        else $error("status word write");
    chk_mirror_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_MIRROR
        |=> processor_status_word_r[15:8] == $past(pwdata[7:0]))
        else $error("mirror pointer write");
    chk_mirror_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_MIRROR
        |=> processor_status_word_r[7:0] == $past(processor_status_word_r[7:0]))
        else $error("mirror touched flags");
    chk_word_order: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_en && paddr == OFS_WORD
        |-> prdata[15:8] == word_r[15:8] && prdata[7:0] == word_r[7:0])
        else $error("word byte order");
    // Main scenarios to be seen
    cov_accept: cover property (@(posedge pclk) irq_accept);
    cov_window: cover property (@(posedge pclk)
        wr_en && paddr == OFS_DIRECT && direct_window_select == 3'h7);
    cov_carry: cover property (@(posedge pclk)
        processor_status_word_r[FLAG_C]);
    cov_bank_limit: cover property (@(posedge pclk)
        wr_en && paddr == OFS_BANKREG && small_ram && bank_select_pointer > 5'h11);
    cov_sub_borrow: cover property (@(posedge pclk)
        wr_en && paddr == OFS_OPERATION && req.op == OP_SUB && borrow_ref);
endmodule : psw_core

// ==== tb/irq_source_model.sv ====
// Behavioural peripheral interrupt sources facing the status block.
// Assumes the bench calls raise and drop from its own clocked sequence.
`timescale 1ns/1ns
module irq_source_model (
    input  wire logic   pclk,
    output logic [23:0] peripheral_request_lines,
    output logic [47:0] source_priority_regs
);
    // All sources idle at the lowest level, so none can win
    initial begin
        peripheral_request_lines = 24'h000000;
        source_priority_regs     = {24{2'h3}};
    end
    // Assert one request with its assigned level just after an edge
    task automatic raise(input int src, input logic [1:0] lvl);
        @(posedge pclk);
        source_priority_regs[2*src +: 2] <= lvl;
        peripheral_request_lines[src]    <= 1'b1;
    endtask : raise
    // Withdraw a request just after an edge
    task automatic drop(input int src);
        @(posedge pclk);
        peripheral_request_lines[src] <= 1'b0;
    endtask : drop
endmodule : irq_source_model

// ==== tb/psw_core_tb.sv ====
// Self-checking bench for the status word block over APB.
// Assumes zero-wait slave and the irq_source_model partner.
`timescale 1ns/1ns
module psw_core_tb;
    import psw_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, small_ram;
    logic        pready, pslverr, irq_accept, slv_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] req_lines;
    logic [47:0] lvl_regs;
    logic [4:0]  irq_source;
    int          err_count, comparisons, cycles;
    // Flag cases: op, a, b, mask, expected flag byte
    localparam logic [35:0] FLAG_CASES [10] = '{36'h1_7F01_8F8A, 36'h1_FF01_8F85,
        36'h2_0000_8F00, 36'h3_0001_8F89, 36'h4_0502_8F00, 36'h3_8001_8F82,
        36'h5_F00F_0C04, 36'h6_8181_0D01, 36'h7_0101_0D05, 36'hA_8080_0C08};

    // Clock at 50 MHz
    always #10 pclk = ~pclk;

    psw_core i_psw_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .peripheral_request_lines(req_lines),
        .source_priority_regs(lvl_regs), .small_ram(small_ram), .irq_accept(irq_accept),
        .irq_source(irq_source));

    irq_source_model i_irq_source_model (.pclk(pclk), .peripheral_request_lines(req_lines),
        .source_priority_regs(lvl_regs));

    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        slv_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic test_reset();
        apb(1'b0, OFS_STATUS_WORD, 32'h0);
        check("status_reset", 32'h0060, {16'h0, rd[15:0]});
        check("irq_idle", 32'h0, {31'h0, irq_accept});
        $display("test_reset done");
    endtask : test_reset

    task automatic test_pointers();
        apb(1'b1, OFS_MIRROR, 32'h0000_00AB);
        apb(1'b0, OFS_STATUS_WORD, 32'h0);
        check("status_ptrs", 32'hAB60, {16'h0, rd[15:0]});
        check("status_no_err", 32'h0, {31'h0, slv_err});
        apb(1'b0, OFS_MIRROR, 32'h0);
        check("mirror_read", 32'hAB, {24'h0, rd[7:0]});
        apb(1'b1, OFS_STATUS_WORD, 32'h0000_2860);
        apb(1'b0, OFS_MIRROR, 32'h0);
        check("mirror_status", 32'h28, {24'h0, rd[7:0]});
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped_err", 32'h1, {31'h0, slv_err});
        $display("test_pointers done");
    endtask : test_pointers

    task automatic test_window();
        logic [15:0] base;
        for (int w = 0; w < 8; w++) begin
            base = (w == 0) ? 16'h0080 : 16'h0100 + 16'(w - 1) * 16'h0080;
            apb(1'b1, OFS_MIRROR, {29'h0, w[2:0]});
            apb(1'b1, OFS_DIRECT, 32'h10);
            apb(1'b0, OFS_DIRECT, 32'h0);
            check("direct_low", 32'h1_0010, {15'h0, rd[16:0]});
            apb(1'b1, OFS_DIRECT, 32'hFF);
            apb(1'b0, OFS_DIRECT, 32'h0);
            check("direct_top", {15'h0, 1'b1, base + 16'h7F}, {15'h0, rd[16:0]});
        end
        apb(1'b1, OFS_MIRROR, 32'h0);
        apb(1'b1, OFS_DIRECT, 32'h8F);
        apb(1'b0, OFS_DIRECT, 32'h0);
        check("direct_hole", 32'h0, {31'h0, rd[16]});
        $display("test_window done");
    endtask : test_window

    task automatic test_flags();
        apb(1'b1, OFS_STATUS_WORD, 32'hEF);
        apb(1'b1, OFS_OPERATION, 32'h0);
        apb(1'b0, OFS_STATUS_WORD, 32'h0);
        check("flags_hold", 32'hEF, {24'h0, rd[7:0]});
        foreach (FLAG_CASES[i]) begin
            apb(1'b1, OFS_OPERATION, {12'h0, FLAG_CASES[i][35:16]});
            apb(1'b0, OFS_STATUS_WORD, 32'h0);
            check("flag_byte", {24'h0, FLAG_CASES[i][7:0]},
                  {24'h0, rd[7:0] & FLAG_CASES[i][15:8]});
        end
        $display("test_flags done");
    endtask : test_flags

    task automatic test_irq();
        apb(1'b1, OFS_STATUS_WORD, 32'h0060);
        i_irq_source_model.raise(3, 2'h1);
        repeat (6) @(posedge pclk);
        check("irq_masked", 32'h0, {31'h0, irq_accept});
        apb(1'b1, OFS_OPERATION, 32'h0008_0000);
        repeat (5) @(posedge pclk);
        check("irq_enabled", 32'h1, {31'h0, irq_accept});
        apb(1'b0, OFS_IRQ, 32'h0);
        check("irq_status", 32'h23, {26'h0, rd[5:0]});
        check("irq_source", 32'h3, {27'h0, irq_source});
        apb(1'b1, OFS_STATUS_WORD, 32'h0030);
        repeat (5) @(posedge pclk);
        check("irq_equal_lvl", 32'h0, {31'h0, irq_accept});
        apb(1'b1, OFS_STATUS_WORD, 32'h0050);
        repeat (5) @(posedge pclk);
        check("irq_lower_lvl", 32'h1, {31'h0, irq_accept});
        apb(1'b1, OFS_OPERATION, 32'h0009_0000);
        repeat (5) @(posedge pclk);
        check("irq_cleared", 32'h0, {31'h0, irq_accept});
        i_irq_source_model.drop(3);
        $display("test_irq done");
    endtask : test_irq

    task automatic test_banks();
        apb(1'b1, OFS_MIRROR, 32'h08);
        apb(1'b1, OFS_BANKREG, 32'h25A);
        apb(1'b1, OFS_MIRROR, 32'h10);
        apb(1'b1, OFS_BANKREG, 32'h2A5);
        apb(1'b1, OFS_MIRROR, 32'h08);
        apb(1'b0, OFS_BANKREG, 32'h0);
        check("bank_slot", 32'h5A, {24'h0, rd[7:0]});
        apb(1'b1, OFS_MIRROR, 32'h90);
        apb(1'b1, OFS_BANKREG, 32'h73C);
        small_ram <= 1'b1;
        apb(1'b1, OFS_BANKREG, 32'h7C3);
        apb(1'b0, OFS_BANKREG, 32'h0);
        check("small_ram_drop", 32'h3C, {24'h0, rd[7:0]});
        small_ram <= 1'b0;
        apb(1'b1, OFS_WORD, 32'h1234);
        apb(1'b0, OFS_WORD, 32'h0);
        check("word_order", 32'h1234, {16'h0, rd[15:0]});
        $display("test_banks done");
    endtask : test_banks

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence: reset for 12 cycles, then every scenario
    initial begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        small_ram   = 1'b0;
        err_count   = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_pointers();
        test_window();
        test_flags();
        test_irq();
        test_banks();
        tally_and_finish();
    end
endmodule : psw_core_tb
